/* logic/tfg_pkg.sv */
// Package of constants and carrier types for the test-frame generator and checker registers
package tfg_pkg;

   // Register offsets
   localparam logic [15:0] CHK_CTRL_OFS   = 16'h0620;
   localparam logic [15:0] GEN_CTRL_OFS   = 16'h0621;
   localparam logic [15:0] BAD_LO_OFS     = 16'h0622;
   localparam logic [15:0] BAD_HI_OFS     = 16'h0623;
   localparam logic [15:0] GEN_CFG_OFS    = 16'h0624;
   localparam logic [15:0] PAT_LO_OFS     = 16'h0625;
   localparam logic [15:0] PAT_MID_OFS    = 16'h0626;
   localparam logic [15:0] PAT_HI_OFS     = 16'h0627;
   localparam logic [15:0] DA_LO_OFS      = 16'h0628;
   localparam logic [15:0] DA_MID_OFS     = 16'h0629;
   localparam logic [15:0] DA_HI_OFS      = 16'h062a;
   localparam logic [15:0] IRQ_STAT_OFS   = 16'h0630;
   localparam logic [15:0] IRQ_MASK_OFS   = 16'h0631;
   localparam logic [15:0] CRC_FLAGS_OFS  = 16'h0638;

   // Reset values
   localparam logic [15:0] GEN_CFG_RST    = 16'h5511;
   localparam logic [15:0] ZERO_RST       = 16'h0000;

   // Bit positions in checker control/status
   localparam int CHK_LOCK_BIT     = 0;
   localparam int CHK_CLEAR_BIT    = 1;
   localparam int CHK_OVF_BIT      = 10;
   localparam int CHK_BUSY_BIT     = 11;
   localparam int CHK_DONE_BIT     = 12;

   // Bit positions in generator control
   localparam int GEN_WRAP_BIT     = 0;
   localparam int GEN_START_BIT    = 1;
   localparam int GEN_STOP_BIT     = 2;

   // Interrupt status bits
   localparam int IRQ_DONE_BIT     = 0;
   localparam int IRQ_OVF_BIT      = 1;
   localparam int IRQ_CRC_BIT      = 2;
   localparam int IRQ_W            = 3;

   // Generator configuration fields
   localparam int FIX_MSB          = 15;
   localparam int FIX_LSB          = 8;
   localparam int MODE_MSB         = 7;
   localparam int MODE_LSB         = 6;
   localparam int VLD_MSB          = 5;
   localparam int VLD_LSB          = 3;
   localparam int CNT_MSB          = 2;
   localparam int CNT_LSB          = 0;

   localparam logic [2:0] VLD_MAX       = 3'h6;
   localparam logic [2:0] CNT_CONTINUOUS = 3'h7;

   // Frame counts per code
   localparam logic [19:0] FRAMES_C0 = 20'h0_0001;
   localparam logic [19:0] FRAMES_C1 = 20'h0_000a;
   localparam logic [19:0] FRAMES_C2 = 20'h0_0064;
   localparam logic [19:0] FRAMES_C3 = 20'h0_03e8;
   localparam logic [19:0] FRAMES_C4 = 20'h0_2710;
   localparam logic [19:0] FRAMES_C5 = 20'h1_86a0;
   localparam logic [19:0] FRAMES_C6 = 20'hf_4240;

   typedef enum logic [1:0]
   {
      TFG_MODE_INCR  = 2'h0,
      TFG_MODE_FIXED = 2'h1,
      TFG_MODE_PRBS  = 2'h2
   } tfg_mode_t;

   // Register bus request
   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } tfg_bus_req_t;

   // Settings handed to the frame datapath
   typedef struct packed
   {
      tfg_mode_t   mode;
      logic [7:0]  fixed_byte;
      logic [2:0]  valid_bytes;
      logic [47:0] pattern;
      logic [47:0] da_match;
   } tfg_gen_cfg_t;

endpackage : tfg_pkg

/* logic/tfg_err_counter.sv */
// Errored-frame counter with saturate or wrap, snapshot and clear
`timescale 1ns/1ns
module tfg_err_counter
   import tfg_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // Control
   input  wire logic        bad_frame_in,
   input  wire logic        wrap_in,
   input  wire logic        lock_in,
   input  wire logic        clear_in,
   // Results
   output logic [31:0]      snap_out,
   output logic             ovf_out,
   output logic             ovf_evt_out
);

   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic [31:0] snap_r;
   logic [31:0] snap_nxt;
   logic        ovf_r;
   logic        ovf_nxt;
   logic        evt_r;
   logic        evt_nxt;

   always_comb
   begin
      cnt_nxt  = cnt_r;
      ovf_nxt  = ovf_r;
      snap_nxt = snap_r;
      evt_nxt  = 1'b0;
      if (lock_in || clear_in)
      begin
         snap_nxt = cnt_r;
      end
      if (clear_in)
      begin
         cnt_nxt = 32'h0000_0000;
         ovf_nxt = 1'b0;
      end
      // An error in the clearing cycle still counts
      if (bad_frame_in)
      begin
         if (&cnt_nxt)
         begin
            ovf_nxt = 1'b1;
            evt_nxt = 1'b1;
            if (wrap_in)
            begin
               cnt_nxt = 32'h0000_0000;
            end
         end
         else
         begin
            cnt_nxt = cnt_nxt + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_r  <= 32'h0000_0000;
         snap_r <= 32'h0000_0000;
         ovf_r  <= 1'b0;
         evt_r  <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         snap_r <= snap_nxt;
         ovf_r  <= ovf_nxt;
         evt_r  <= evt_nxt;
      end
   end

   assign snap_out    = snap_r;
   assign ovf_out     = ovf_r;
   assign ovf_evt_out = evt_r;

endmodule : tfg_err_counter

/* logic/tfg_regs.sv */
// Register file and frame-count sequencer of the test-frame generator and checker
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
// How it works
// - 32-bit errored-frame count readable as two read-only halves at 0x622 and 0x623.
// - Writing checker control bit 0 or 1 snapshots both count halves.
// - With counting mode zero the count sticks at all ones.
// - Config bits 15:8 hold the fixed payload byte, reset 0x55.
// - Config bits 7:6 pick incremental, fixed or pseudo-random payload; resets incremental.
// - Config bits 5:3 give valid pattern bytes, 7 treated as 6, reset 2.
// - Config bits 2:0 pick 1 to 1000000 frames or continuous; reset code 1.
// - 48-bit pattern over 0x625..0x627, read/write, reset zero.
// - 48-bit destination match value over 0x628..0x62A, read/write, reset zero.
// - Bit 0 write only freezes; bit 1 freezes then clears counters and overflow.
// - Busy while frames are produced; done once all requested frames are sent.
module tfg_regs
   import tfg_pkg::*;
(
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         rst_in,
   // Register port
   input  tfg_bus_req_t      bus_in,
   output logic [15:0]       rdata_out,
   // Checker and transmit events
   input  wire logic         bad_frame_in,
   input  wire logic         tx_frame_sent_in,
   input  wire logic         tx_bad_crc_in,
   input  wire logic         rx_bad_crc_in,
   // Datapath control
   output tfg_gen_cfg_t      gen_cfg_out,
   output logic              gen_busy_out,
   output logic              gen_done_out,
   // Interrupt
   output logic              irq_out
);

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} tfg_state_t;

   // Frame total for a count code; zero means continuous
   function automatic logic [19:0] frames_for(input logic [2:0] code);
      case (code)
         3'h0:    frames_for = FRAMES_C0;
         3'h1:    frames_for = FRAMES_C1;
         3'h2:    frames_for = FRAMES_C2;
         3'h3:    frames_for = FRAMES_C3;
         3'h4:    frames_for = FRAMES_C4;
         3'h5:    frames_for = FRAMES_C5;
         3'h6:    frames_for = FRAMES_C6;
         default: frames_for = 20'h0_0000;
      endcase
   endfunction : frames_for

   function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   // Configuration state
   logic [15:0]      cfg_r;
   logic [15:0]      cfg_nxt;
   logic [47:0]      pat_r;
   logic [47:0]      pat_nxt;
   logic [47:0]      da_r;
   logic [47:0]      da_nxt;
   logic             wrap_r;
   logic             wrap_nxt;
   logic [IRQ_W-1:0] stat_r;
   logic [IRQ_W-1:0] stat_nxt;
   logic [IRQ_W-1:0] mask_r;
   logic [IRQ_W-1:0] mask_nxt;
   logic [1:0]       crc_r;
   logic [1:0]       crc_nxt;
   logic             irq_r;
   logic             irq_nxt;
   logic [15:0]      rdata_r;
   logic [15:0]      rdata_nxt;
   tfg_gen_cfg_t     gcfg_r;
   tfg_gen_cfg_t     gcfg_nxt;

   // Sequencer state
   tfg_state_t       st_r;
   tfg_state_t       st_nxt;
   logic [19:0]      sent_r;
   logic [19:0]      sent_nxt;
   logic [19:0]      goal_r;
   logic [19:0]      goal_nxt;
   logic             busy_r;
   logic             busy_nxt;
   logic             done_r;
   logic             done_nxt;
   logic             done_evt;

   // Decoded strobes
   logic             chk_wr;
   logic             lock_pulse;
   logic             clear_pulse;
   logic             start_pulse;
   logic             stop_pulse;
   logic [31:0]      snap;
   logic             ovf;
   logic             ovf_evt;

   assign chk_wr      = bus_in.wr && hit(bus_in.addr, CHK_CTRL_OFS);
   assign lock_pulse  = chk_wr && bus_in.wdata[CHK_LOCK_BIT];
   assign clear_pulse = chk_wr && bus_in.wdata[CHK_CLEAR_BIT];
   assign start_pulse = bus_in.wr && hit(bus_in.addr, GEN_CTRL_OFS)
                        && bus_in.wdata[GEN_START_BIT];
   assign stop_pulse  = bus_in.wr && hit(bus_in.addr, GEN_CTRL_OFS)
                        && bus_in.wdata[GEN_STOP_BIT];

   tfg_err_counter u_err_counter
   (
      .sys_clk_in   (sys_clk_in),
      .rst_in       (rst_in),
      .bad_frame_in (bad_frame_in),
      .wrap_in      (wrap_r),
      .lock_in      (lock_pulse),
      .clear_in     (clear_pulse),
      .snap_out     (snap),
      .ovf_out      (ovf),
      .ovf_evt_out  (ovf_evt)
   );

   // Register writes, reads and interrupt
   always_comb
   begin
      cfg_nxt   = cfg_r;
      pat_nxt   = pat_r;
      da_nxt    = da_r;
      wrap_nxt  = wrap_r;
      mask_nxt  = mask_r;
      stat_nxt  = stat_r;
      rdata_nxt = 16'h0000;
      crc_nxt   = {rx_bad_crc_in, tx_bad_crc_in};
      if (bus_in.wr)
      begin
         if (hit(bus_in.addr, GEN_CFG_OFS))  cfg_nxt = bus_in.wdata;
         if (hit(bus_in.addr, PAT_LO_OFS))   pat_nxt[15:0]  = bus_in.wdata;
         if (hit(bus_in.addr, PAT_MID_OFS))  pat_nxt[31:16] = bus_in.wdata;
         if (hit(bus_in.addr, PAT_HI_OFS))   pat_nxt[47:32] = bus_in.wdata;
         if (hit(bus_in.addr, DA_LO_OFS))    da_nxt[15:0]   = bus_in.wdata;
         if (hit(bus_in.addr, DA_MID_OFS))   da_nxt[31:16]  = bus_in.wdata;
         if (hit(bus_in.addr, DA_HI_OFS))    da_nxt[47:32]  = bus_in.wdata;
         if (hit(bus_in.addr, GEN_CTRL_OFS)) wrap_nxt = bus_in.wdata[GEN_WRAP_BIT];
         if (hit(bus_in.addr, IRQ_MASK_OFS)) mask_nxt = bus_in.wdata[IRQ_W-1:0];
         if (hit(bus_in.addr, IRQ_STAT_OFS)) stat_nxt = stat_r & ~bus_in.wdata[IRQ_W-1:0];
      end
      // Events set after the clear so that they win
      if (done_evt)       stat_nxt[IRQ_DONE_BIT] = 1'b1;
      if (ovf_evt)        stat_nxt[IRQ_OVF_BIT]  = 1'b1;
      if (|crc_nxt && !(|crc_r)) stat_nxt[IRQ_CRC_BIT] = 1'b1;
      irq_nxt = |(stat_nxt & mask_nxt);
      if (bus_in.rd)
      begin
         case (bus_in.addr)
            CHK_CTRL_OFS:
            begin
               rdata_nxt[CHK_OVF_BIT]  = ovf;
               rdata_nxt[CHK_BUSY_BIT] = busy_r;
               rdata_nxt[CHK_DONE_BIT] = done_r;
            end
            GEN_CTRL_OFS:  rdata_nxt[GEN_WRAP_BIT] = wrap_r;
            BAD_LO_OFS:    rdata_nxt = snap[15:0];
            BAD_HI_OFS:    rdata_nxt = snap[31:16];
            GEN_CFG_OFS:   rdata_nxt = cfg_r;
            PAT_LO_OFS:    rdata_nxt = pat_r[15:0];
            PAT_MID_OFS:   rdata_nxt = pat_r[31:16];
            PAT_HI_OFS:    rdata_nxt = pat_r[47:32];
            DA_LO_OFS:     rdata_nxt = da_r[15:0];
            DA_MID_OFS:    rdata_nxt = da_r[31:16];
            DA_HI_OFS:     rdata_nxt = da_r[47:32];
            IRQ_STAT_OFS:  rdata_nxt[IRQ_W-1:0] = stat_r;
            IRQ_MASK_OFS:  rdata_nxt[IRQ_W-1:0] = mask_r;
            CRC_FLAGS_OFS: rdata_nxt[1:0] = crc_r;
            default:       rdata_nxt = 16'h0000;
         endcase
      end
   end

   // Datapath settings decoded from the configuration
   always_comb
   begin
      gcfg_nxt.fixed_byte = cfg_r[FIX_MSB:FIX_LSB];
      if (cfg_r[MODE_MSB])
      begin
         gcfg_nxt.mode = TFG_MODE_PRBS;
      end
      else if (cfg_r[MODE_LSB])
      begin
         gcfg_nxt.mode = TFG_MODE_FIXED;
      end
      else
      begin
         gcfg_nxt.mode = TFG_MODE_INCR;
      end
      if (cfg_r[VLD_MSB:VLD_LSB] > VLD_MAX)
      begin
         gcfg_nxt.valid_bytes = VLD_MAX;
      end
      else
      begin
         gcfg_nxt.valid_bytes = cfg_r[VLD_MSB:VLD_LSB];
      end
      gcfg_nxt.pattern  = pat_r;
      gcfg_nxt.da_match = da_r;
   end

   // Frame-count sequencer
   always_comb
   begin
      st_nxt   = st_r;
      sent_nxt = sent_r;
      goal_nxt = goal_r;
      done_evt = 1'b0;
      case (st_r)
         ST_IDLE, ST_DONE:
         begin
            if (start_pulse)
            begin
               goal_nxt = frames_for(cfg_r[CNT_MSB:CNT_LSB]);
               sent_nxt = 20'h0_0000;
               st_nxt   = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (stop_pulse)
            begin
               st_nxt = ST_IDLE;
            end
            else if (tx_frame_sent_in)
            begin
               sent_nxt = sent_r + 20'h0_0001;
               // A zero goal runs without end
               if (goal_r != 20'h0_0000 && sent_nxt == goal_r)
               begin
                  st_nxt   = ST_DONE;
                  done_evt = 1'b1;
               end
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      busy_nxt = (st_nxt == ST_RUN);
      done_nxt = (st_nxt == ST_DONE);
   end

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cfg_r   <= GEN_CFG_RST;
         pat_r   <= 48'h0000_0000_0000;
         da_r    <= 48'h0000_0000_0000;
         wrap_r  <= 1'b0;
         stat_r  <= '0;
         mask_r  <= '0;
         crc_r   <= 2'h0;
         irq_r   <= 1'b0;
         rdata_r <= ZERO_RST;
         gcfg_r  <= '0;
         st_r    <= ST_IDLE;
         sent_r  <= 20'h0_0000;
         goal_r  <= 20'h0_0000;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
      end
      else
      begin
         cfg_r   <= cfg_nxt;
         pat_r   <= pat_nxt;
         da_r    <= da_nxt;
         wrap_r  <= wrap_nxt;
         stat_r  <= stat_nxt;
         mask_r  <= mask_nxt;
         crc_r   <= crc_nxt;
         irq_r   <= irq_nxt;
         rdata_r <= rdata_nxt;
         gcfg_r  <= gcfg_nxt;
         st_r    <= st_nxt;
         sent_r  <= sent_nxt;
         goal_r  <= goal_nxt;
         busy_r  <= busy_nxt;
         done_r  <= done_nxt;
      end
   end

   assign rdata_out    = rdata_r;
   assign gen_cfg_out  = gcfg_r;
   assign gen_busy_out = busy_r;
   assign gen_done_out = done_r;
   assign irq_out      = irq_r;

endmodule : tfg_regs

/* bench/tfg_regs_sva.sv */
// Assertions on the register port and generator status of the frame test block
`timescale 1ns/1ns
module tfg_regs_chk
   import tfg_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // Register port
   input  tfg_bus_req_t     bus_in,
   input  wire logic [15:0] rdata_out,
   // Datapath and status
   input  tfg_gen_cfg_t     gen_cfg_out,
   input  wire logic        gen_busy_out,
   input  wire logic        gen_done_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_wr(a);
      bus_in.wr && bus_in.addr == a;
   endsequence
   sequence s_start;
      bus_in.wr && bus_in.addr == GEN_CTRL_OFS && bus_in.wdata[GEN_START_BIT] && !gen_busy_out;
   endsequence

   a_rdata_idle_zero: assert property (!$past(bus_in.rd) |-> rdata_out == 16'h0000)
      else $error("read data not zero outside a read answer");
   a_fixed_byte_load: assert property (s_wr(GEN_CFG_OFS) |->
      ##2 gen_cfg_out.fixed_byte == $past(bus_in.wdata[15:8], 2))
      else $error("fixed byte not taken from config write");
   a_mode_decode: assert property (s_wr(GEN_CFG_OFS) |-> ##2 gen_cfg_out.mode ==
      ($past(bus_in.wdata[7], 2) ? TFG_MODE_PRBS :
       tfg_mode_t'({1'b0, $past(bus_in.wdata[6], 2)})))
      else $error("payload mode decoded wrongly");
   a_valid_clamp: assert property (s_wr(GEN_CFG_OFS) |-> ##2 gen_cfg_out.valid_bytes ==
      ($past(bus_in.wdata[5:3], 2) == 3'h7 ? VLD_MAX : $past(bus_in.wdata[5:3], 2)))
      else $error("valid byte count wrong");
   a_pattern_load: assert property (s_wr(PAT_HI_OFS) |->
      ##2 gen_cfg_out.pattern[47:32] == $past(bus_in.wdata, 2))
      else $error("pattern high part not loaded");
   a_match_load: assert property (s_wr(DA_LO_OFS) |->
      ##2 gen_cfg_out.da_match[15:0] == $past(bus_in.wdata, 2))
      else $error("match low part not loaded");
   a_busy_on_start: assert property (s_start |=> gen_busy_out && !gen_done_out)
      else $error("busy not raised by start");
   a_done_holds: assert property (gen_done_out
      && !(bus_in.wr && bus_in.addr == GEN_CTRL_OFS) |=> gen_done_out)
      else $error("done dropped without start");
   a_busy_done_excl: assert property (!(gen_busy_out && gen_done_out))
      else $error("busy and done together");
endmodule : tfg_regs_chk

bind tfg_regs tfg_regs_chk u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in),
   .rdata_out(rdata_out), .gen_cfg_out(gen_cfg_out), .gen_busy_out(gen_busy_out),
   .gen_done_out(gen_done_out));

/* bench/tfg_regs_test.sv */
// Self-checking bench for the frame test register block
`timescale 1ns/1ns
module tfg_regs_test
   import tfg_pkg::*;
();
   logic          sys_clk;
   logic          rst;
   tfg_bus_req_t  bus;
   logic [15:0]   rdata;
   logic          bad_frame;
   logic          frame_sent;
   logic          tx_crc;
   logic          rx_crc;
   tfg_gen_cfg_t  cfg;
   logic          busy;
   logic          done;
   logic          irq;
   int            err_count;
   int            n_compared;

   tfg_regs DUT
   (
      .sys_clk_in       (sys_clk),
      .rst_in           (rst),
      .bus_in           (bus),
      .rdata_out        (rdata),
      .bad_frame_in     (bad_frame),
      .tx_frame_sent_in (frame_sent),
      .tx_bad_crc_in    (tx_crc),
      .rx_bad_crc_in    (rx_crc),
      .gen_cfg_out      (cfg),
      .gen_busy_out     (busy),
      .gen_done_out     (done),
      .irq_out          (irq)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : settle

   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      bus <= '0;
   endtask : wr_reg

   task automatic rd_chk(input string name, input logic [15:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge sys_clk);
      bus <= '0;
      @(negedge sys_clk);
      check(name, rdata, exp);
   endtask : rd_chk

   // One-cycle event pulses: transmitted frames or errored frames
   task automatic pulses(input bit tx, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         if (tx) frame_sent <= 1'b1;
         else bad_frame <= 1'b1;
         @(posedge sys_clk);
         frame_sent <= 1'b0;
         bad_frame <= 1'b0;
      end
   endtask : pulses

   task automatic t_reset_values;
      for (int i = 0; i < 9; i++)
         rd_chk("reset value", BAD_LO_OFS + 16'(i), i == 2 ? GEN_CFG_RST : ZERO_RST);
      rd_chk("unmapped", 16'h0700, ZERO_RST);
      check("mode", cfg.mode, TFG_MODE_INCR);
      check("fixed byte", cfg.fixed_byte, 8'h55);
      check("valid bytes", cfg.valid_bytes, 3'h2);
      $display("t_reset_values finished");
   endtask : t_reset_values

   task automatic t_config;
      logic [15:0] d;
      for (int v = 0; v < 8; v++)
      begin
         d = {8'ha0 + 8'(v), 2'(v), 3'(v), 3'(7 - v)};
         wr_reg(GEN_CFG_OFS, d);
         settle(2);
         check("mode", cfg.mode, v[1] ? TFG_MODE_PRBS : tfg_mode_t'(v[0]));
         check("fixed byte", cfg.fixed_byte, d[15:8]);
         check("valid bytes", cfg.valid_bytes, v == 7 ? VLD_MAX : 3'(v));
         rd_chk("config", GEN_CFG_OFS, d);
      end
      $display("t_config finished");
   endtask : t_config

   task automatic t_patterns;
      for (int i = 0; i < 6; i++)
         wr_reg(PAT_LO_OFS + 16'(i), 16'h1111 * 16'(i + 1));
      settle(2);
      check("pattern", cfg.pattern, 48'h3333_2222_1111);
      check("match", cfg.da_match, 48'h6666_5555_4444);
      for (int i = 0; i < 6; i++)
         rd_chk("pattern reg", PAT_LO_OFS + 16'(i), 16'h1111 * 16'(i + 1));
      wr_reg(BAD_HI_OFS, 16'hffff);
      rd_chk("count high", BAD_HI_OFS, ZERO_RST);
      $display("t_patterns finished");
   endtask : t_patterns

   task automatic t_counter;
      pulses(1'b0, 3);
      rd_chk("count low", BAD_LO_OFS, 16'h0000);
      wr_reg(CHK_CTRL_OFS, 16'h0001);
      rd_chk("count low", BAD_LO_OFS, 16'h0003);
      rd_chk("count high", BAD_HI_OFS, 16'h0000);
      pulses(1'b0, 2);
      rd_chk("count low", BAD_LO_OFS, 16'h0003);
      wr_reg(CHK_CTRL_OFS, 16'h0002);
      rd_chk("count low", BAD_LO_OFS, 16'h0005);
      wr_reg(CHK_CTRL_OFS, 16'h0001);
      rd_chk("count low", BAD_LO_OFS, 16'h0000);
      @(posedge sys_clk);
      tx_crc <= 1'b1;
      rd_chk("crc flags", CRC_FLAGS_OFS, 16'h0001);
      @(posedge sys_clk);
      tx_crc <= 1'b0;
      rx_crc <= 1'b1;
      rd_chk("crc flags", CRC_FLAGS_OFS, 16'h0002);
      @(posedge sys_clk);
      rx_crc <= 1'b0;
      wr_reg(GEN_CTRL_OFS, 16'h0001);
      rd_chk("count mode", GEN_CTRL_OFS, 16'h0001);
      $display("t_counter finished");
   endtask : t_counter

   task automatic t_generator;
      wr_reg(GEN_CFG_OFS, 16'h5510);
      wr_reg(GEN_CTRL_OFS, 16'h0002);
      @(negedge sys_clk);
      check("busy", busy, 1'b1);
      pulses(1'b1, 1);
      @(negedge sys_clk);
      check("busy done", {busy, done}, 2'b01);
      check("irq masked", irq, 1'b0);
      wr_reg(IRQ_MASK_OFS, 16'h0001);
      settle(1);
      check("irq", irq, 1'b1);
      wr_reg(IRQ_STAT_OFS, 16'h0007);
      settle(1);
      check("irq cleared", irq, 1'b0);
      wr_reg(GEN_CFG_OFS, 16'h5511);
      wr_reg(GEN_CTRL_OFS, 16'h0002);
      pulses(1'b1, 9);
      @(negedge sys_clk);
      check("busy", busy, 1'b1);
      pulses(1'b1, 1);
      @(negedge sys_clk);
      check("busy done", {busy, done}, 2'b01);
      rd_chk("status", CHK_CTRL_OFS, 16'h1000);
      wr_reg(GEN_CFG_OFS, 16'h5517);
      wr_reg(GEN_CTRL_OFS, 16'h0002);
      pulses(1'b1, 12);
      @(negedge sys_clk);
      check("busy", busy, 1'b1);
      wr_reg(GEN_CTRL_OFS, 16'h0004);
      settle(1);
      check("busy", busy, 1'b0);
      $display("t_generator finished");
   endtask : t_generator

   task automatic stop_test;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   initial
   begin
      rst = 1'b1;
      bus = '0;
      bad_frame = 1'b0;
      frame_sent = 1'b0;
      tx_crc = 1'b0;
      rx_crc = 1'b0;
      err_count = 0;
      n_compared = 0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      settle(1);
      t_reset_values();
      t_config();
      t_patterns();
      t_counter();
      t_generator();
      stop_test();
   end

   // Cuts a hung run short
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      stop_test();
   end
endmodule : tfg_regs_test
